// ===== src/arc_regs.svh
// Register indices, field positions, reset values and timing counts of the result block.
// Assumes a 32-bit register bus, with byte address = 4 * register index.
`ifndef ARC_REGS_SVH
`define ARC_REGS_SVH

// Register indices
`define ARC_IDX_CTL0       6'h00
`define ARC_IDX_CTL2       6'h04
`define ARC_IDX_OVF_STAT   6'h06
`define ARC_IDX_OVF_MASK   6'h08
`define ARC_IDX_IFG        6'h0a
`define ARC_IDX_IE         6'h0c
`define ARC_IDX_IV         6'h0e
`define ARC_IDX_MCTL_BASE  6'h10
`define ARC_IDX_MEM_BASE   6'h20

// Field positions
`define ARC_CTL0_ENC       1
`define ARC_CTL2_DF        3
`define ARC_CTL2_RES_LSB   4
`define ARC_CTL2_RES_MSB   5
`define ARC_MCTL_EOS       7
`define ARC_MCTL_SREF_MSB  6
`define ARC_MCTL_SREF_LSB  4
`define ARC_MCTL_INCH_MSB  3
`define ARC_MCTL_INCH_LSB  0
`define ARC_OVF_RESULT     0
`define ARC_OVF_TIME       1

// Reset values
`define ARC_RST_RES        2'h2
`define ARC_RST_DF         1'h0
`define ARC_RST_MCTL       8'h00
`define ARC_RST_WORD16     16'h0000

// Resolution codes and conversion times in converter clocks
`define ARC_RES_8          2'h0
`define ARC_RES_10         2'h1
`define ARC_RES_12         2'h2
`define ARC_CYC_8          4'h9
`define ARC_CYC_10         4'hb
`define ARC_CYC_12         4'hd

// Vector codes
`define ARC_IV_NONE        16'h0000
`define ARC_IV_RESULT_OVF  16'h0002
`define ARC_IV_TIME_OVF    16'h0004
`define ARC_IV_SLOT0       16'h0006

`endif

// ===== src/arc_pkg.sv
// Types of the result and interrupt block.
// Assumes arc_regs.svh for widths of fields.
package arc_pkg;

	typedef enum logic {ARC_IDLE, ARC_ACK} arc_bus_state_t;

	typedef struct packed {
		arc_bus_state_t   bus_state;
		logic             waitreq;
		logic [31:0]      rdata;
		logic             irq;
		logic             enable;
		logic [1:0]       res;
		logic             fmt;
		logic [15:0][7:0] mctl;
		logic [15:0][11:0] mem;
		logic [15:0]      ie;
		logic [15:0]      ifg;
		logic [1:0]       ovf;
		logic [1:0]       ovf_mask;
		logic [7:0]       sel_ctrl;
		logic [3:0]       cycles;
	} arc_state_t;

endpackage : arc_pkg

// ===== src/arc_fmt.sv
// Read-back formatter of one result slot.
// Assumes the stored value is right-justified unsigned at the given resolution.
`timescale 1ns/1ps
`include "arc_regs.svh"

module arc_fmt (
	input  wire logic [11:0] raw,
	input  wire logic [1:0]  res,
	input  wire logic        fmt,
	output logic      [15:0] word
);

	logic [15:0] unsigned_word;
	logic [15:0] left_word;

	always_comb begin
		case (res)
			`ARC_RES_8: begin
				unsigned_word = {8'h00, raw[7:0]};
				left_word     = {raw[7:0], 8'h00};
			end
			`ARC_RES_10: begin
				unsigned_word = {6'h00, raw[9:0]};
				left_word     = {raw[9:0], 6'h00};
			end
			default: begin
				unsigned_word = {4'h0, raw};
				left_word     = {raw, 4'h0};
			end
		endcase
		if (fmt) begin
			word = {~left_word[15], left_word[14:0]};
		end else begin
			word = unsigned_word;
		end
	end

endmodule : arc_fmt

// ===== src/arc_top.sv
// Result slots, slot control bytes, slot interrupt flags and vector word of a 12-bit converter.
// Assumes the converter core runs on this clock and Avalon-MM with waitrequest as register bus.
// Behaviour
// - With format bit 0 a slot reads right-justified with unused upper bits zero.
// - With format bit 1 a slot reads left-justified two's complement with unused low bits zero.
// - Results are stored right-justified unsigned and only converted on the read path.
// - Slot control bytes change only while conversion is disabled.
// - Bit 7 of a slot control byte marks the last conversion of a sequence.
// - Bits 6-4 of a slot control byte choose the reference pairing.
// - Bits 3-0 of a slot control byte choose the input channel.
// - Each enable bit gates the interrupt request of its slot flag.
// - Loading a result into a slot sets that slot's flag.
// - Accessing a slot's result clears its flag, and software writes may clear flags.
// - The vector word reports the highest-priority pending source by its even code.
// - A two-bit resolution field picks 8, 10 or 12 bits taking 9, 11 or 13 clocks.
// - A format bit picks unsigned or signed read-back independent of storage.
`timescale 1ns/1ps
`include "arc_regs.svh"

module arc_top (
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic [7:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	input  wire logic [3:0]  byteenable,
	output logic      [31:0] readdata,
	output logic             waitrequest,
	output logic             irq,
	input  wire logic        load_valid,
	input  wire logic [3:0]  load_slot,
	input  wire logic [11:0] load_data,
	input  wire logic        time_overflow,
	input  wire logic [3:0]  ctrl_slot,
	output logic             end_of_sequence_mark,
	output logic      [2:0]  reference_select,
	output logic      [3:0]  input_channel_select,
	output logic             conversion_enable,
	output logic      [1:0]  resolution_select,
	output logic             readback_format,
	output logic      [3:0]  conversion_cycles
);

	arc_pkg::arc_state_t s_reg;
	arc_pkg::arc_state_t s_next;

	logic [5:0]  idx;
	logic        req;
	logic        is_mem;
	logic        is_mctl;
	logic [3:0]  acc_slot;
	logic [15:0] fmt_word;
	logic [15:0] vector_code;
	logic [15:0] wr16;
	logic [15:0] wmask16;
	logic [11:0] load_masked;

	assign idx      = address[7:2];
	assign is_mem   = (idx[5:4] == 2'(`ARC_IDX_MEM_BASE >> 4)) || (idx[5:4] == 2'h3);
	assign is_mctl  = (idx[5:4] == 2'(`ARC_IDX_MCTL_BASE >> 4));
	assign acc_slot = is_mem ? idx[4:1] : idx[3:0];
	assign wmask16  = {{8{byteenable[1]}}, {8{byteenable[0]}}};
	assign wr16     = writedata[15:0];

	// Slot read-back formatter
	arc_fmt u_fmt (
		.raw  (s_reg.mem[acc_slot]),
		.res  (s_reg.res),
		.fmt  (s_reg.fmt),
		.word (fmt_word)
	);

	// Priority vector
	always_comb begin
		vector_code = `ARC_IV_NONE;
		if (s_reg.ovf[`ARC_OVF_RESULT]) begin
			vector_code = `ARC_IV_RESULT_OVF;
		end else if (s_reg.ovf[`ARC_OVF_TIME]) begin
			vector_code = `ARC_IV_TIME_OVF;
		end else begin
			for (int i = 15; i >= 0; i--) begin
				if (s_reg.ifg[i]) begin
					vector_code = `ARC_IV_SLOT0 + {11'h000, 4'(i), 1'b0};
				end
			end
		end
	end

	// Load masked to the active resolution, kept right-justified
	always_comb begin
		case (s_reg.res)
			`ARC_RES_8:  load_masked = {4'h0, load_data[7:0]};
			`ARC_RES_10: load_masked = {2'h0, load_data[9:0]};
			default:     load_masked = load_data;
		endcase
	end

	assign req = (read || write) && (s_reg.bus_state == arc_pkg::ARC_IDLE);

	always_comb begin
		logic [1:0]  ovf_set;
		logic [15:0] ifg_set;
		logic [15:0] ifg_clr;
		logic [1:0]  ovf_clr;
		logic [15:0] ifg_wr;
		logic        ifg_write;
		ovf_set   = 2'h0;
		ifg_set   = 16'h0000;
		ifg_clr   = 16'h0000;
		ovf_clr   = 2'h0;
		ifg_wr    = 16'h0000;
		ifg_write = 1'b0;
		s_next    = s_reg;
		s_next.waitreq = 1'b1;

		// Core side events
		if (load_valid) begin
			s_next.mem[load_slot] = load_masked;
			ifg_set[load_slot] = 1'b1;
			if (s_reg.ifg[load_slot]) begin
				ovf_set[`ARC_OVF_RESULT] = 1'b1;
			end
		end
		if (time_overflow) begin
			ovf_set[`ARC_OVF_TIME] = 1'b1;
		end

		// Bus access
		case (s_reg.bus_state)
			arc_pkg::ARC_IDLE: begin
				if (req) begin
					s_next.bus_state = arc_pkg::ARC_ACK;
					s_next.waitreq   = 1'b0;
					s_next.rdata     = 32'h0000_0000;
					if (is_mem && !idx[0]) begin
						ifg_clr[acc_slot] = 1'b1;
						if (read) begin
							s_next.rdata = {16'h0000, fmt_word};
						end else if (byteenable[1:0] != 2'h0) begin
							s_next.mem[acc_slot] = wr16[11:0];
						end
					end else if (is_mctl) begin
						if (read) begin
							s_next.rdata = {24'h000000, s_reg.mctl[acc_slot]};
						end else if (!s_reg.enable && byteenable[0]) begin
							s_next.mctl[acc_slot] = writedata[7:0];
						end
					end else begin
						case (idx)
							`ARC_IDX_CTL0: begin
								if (read) begin
									s_next.rdata[`ARC_CTL0_ENC] = s_reg.enable;
								end else if (byteenable[0]) begin
									s_next.enable = writedata[`ARC_CTL0_ENC];
								end
							end
							`ARC_IDX_CTL2: begin
								if (read) begin
									s_next.rdata[`ARC_CTL2_RES_MSB:`ARC_CTL2_RES_LSB] = s_reg.res;
									s_next.rdata[`ARC_CTL2_DF] = s_reg.fmt;
								end else if (!s_reg.enable && byteenable[0]) begin
									s_next.res = writedata[`ARC_CTL2_RES_MSB:`ARC_CTL2_RES_LSB];
									s_next.fmt = writedata[`ARC_CTL2_DF];
								end
							end
							`ARC_IDX_OVF_STAT: begin
								if (read) begin
									s_next.rdata = {30'h00000000, s_reg.ovf};
									ovf_clr = 2'h3;
								end
							end
							`ARC_IDX_OVF_MASK: begin
								if (read) begin
									s_next.rdata = {30'h00000000, s_reg.ovf_mask};
								end else if (byteenable[0]) begin
									s_next.ovf_mask = writedata[1:0];
								end
							end
							`ARC_IDX_IFG: begin
								if (read) begin
									s_next.rdata = {16'h0000, s_reg.ifg};
								end else begin
									ifg_write = 1'b1;
									ifg_wr = (s_reg.ifg & ~wmask16) | (wr16 & wmask16);
								end
							end
							`ARC_IDX_IE: begin
								if (read) begin
									s_next.rdata = {16'h0000, s_reg.ie};
								end else begin
									s_next.ie = (s_reg.ie & ~wmask16) | (wr16 & wmask16);
								end
							end
							`ARC_IDX_IV: begin
								if (read) begin
									s_next.rdata = {16'h0000, vector_code};
									if (vector_code == `ARC_IV_RESULT_OVF) begin
										ovf_clr[`ARC_OVF_RESULT] = 1'b1;
									end else if (vector_code == `ARC_IV_TIME_OVF) begin
										ovf_clr[`ARC_OVF_TIME] = 1'b1;
									end
								end
							end
							default: begin
								s_next.rdata = 32'h0000_0000;
							end
						endcase
					end
				end
			end
			arc_pkg::ARC_ACK: begin
				s_next.bus_state = arc_pkg::ARC_IDLE;
			end
			default: begin
				s_next.bus_state = arc_pkg::ARC_IDLE;
			end
		endcase

		// Flag update, hardware set wins over any clear
		if (ifg_write) begin
			s_next.ifg = (ifg_wr & ~ifg_clr) | ifg_set;
		end else begin
			s_next.ifg = (s_reg.ifg & ~ifg_clr) | ifg_set;
		end
		s_next.ovf = (s_reg.ovf & ~ovf_clr) | ovf_set;

		// Interrupt level
		s_next.irq = |(s_next.ifg & s_next.ie) || |(s_next.ovf & s_next.ovf_mask);

		// Control byte of the slot the core asks about
		s_next.sel_ctrl = s_next.mctl[ctrl_slot];

		// Conversion time for the resolution
		case (s_next.res)
			`ARC_RES_8:  s_next.cycles = `ARC_CYC_8;
			`ARC_RES_10: s_next.cycles = `ARC_CYC_10;
			default:     s_next.cycles = `ARC_CYC_12;
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s_reg.bus_state <= arc_pkg::ARC_IDLE;
			s_reg.waitreq   <= 1'b1;
			s_reg.rdata     <= 32'h0000_0000;
			s_reg.irq       <= 1'b0;
			s_reg.enable    <= 1'b0;
			s_reg.res       <= `ARC_RST_RES;
			s_reg.fmt       <= `ARC_RST_DF;
			s_reg.mctl      <= '0;
			s_reg.mem       <= '0;
			s_reg.ie        <= `ARC_RST_WORD16;
			s_reg.ifg       <= `ARC_RST_WORD16;
			s_reg.ovf       <= 2'h0;
			s_reg.ovf_mask  <= 2'h0;
			s_reg.sel_ctrl  <= `ARC_RST_MCTL;
			s_reg.cycles    <= `ARC_CYC_12;
		end else begin
			s_reg <= s_next;
		end
	end

	assign readdata             = s_reg.rdata;
	assign waitrequest          = s_reg.waitreq;
	assign irq                  = s_reg.irq;
	assign end_of_sequence_mark = s_reg.sel_ctrl[`ARC_MCTL_EOS];
	assign reference_select     = s_reg.sel_ctrl[`ARC_MCTL_SREF_MSB:`ARC_MCTL_SREF_LSB];
	assign input_channel_select = s_reg.sel_ctrl[`ARC_MCTL_INCH_MSB:`ARC_MCTL_INCH_LSB];
	assign conversion_enable    = s_reg.enable;
	assign resolution_select    = s_reg.res;
	assign readback_format      = s_reg.fmt;
	assign conversion_cycles    = s_reg.cycles;

endmodule : arc_top

// ===== dv/arc_top_monitor.sv
// Port checker of the result and interrupt block.
// Assumes arc_top ports and the indices of arc_regs.svh.
`timescale 1ns/1ps
`include "arc_regs.svh"

module arc_top_monitor (
	input wire logic        clock,
	input wire logic        rst,
	input wire logic [7:0]  address,
	input wire logic        read,
	input wire logic        write,
	input wire logic [31:0] readdata,
	input wire logic        waitrequest,
	input wire logic        irq,
	input wire logic        load_valid,
	input wire logic        time_overflow,
	input wire logic [3:0]  ctrl_slot,
	input wire logic        end_of_sequence_mark,
	input wire logic [2:0]  reference_select,
	input wire logic [3:0]  input_channel_select,
	input wire logic        conversion_enable,
	input wire logic [1:0]  resolution_select,
	input wire logic        readback_format,
	input wire logic [3:0]  conversion_cycles
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	a_cyc_eight: assert property (
		resolution_select == 2'h0 |-> conversion_cycles == 4'h9) else $error("bad 8 bit time");
	a_cyc_ten: assert property (
		resolution_select == 2'h1 |-> conversion_cycles == 4'hb) else $error("bad 10 bit time");
	a_cyc_twelve: assert property (
		resolution_select[1] |-> conversion_cycles == 4'hd) else $error("bad 12 bit time");
	a_ctl_lock: assert property (
		conversion_enable && $past(conversion_enable) && $stable(ctrl_slot) |=>
		$stable({end_of_sequence_mark, reference_select, input_channel_select}))
		else $error("control byte changed while enabled");
	a_vector_even: assert property (
		read && waitrequest && address[7:2] == `ARC_IDX_IV |=>
		!waitrequest && readdata[31:6] == 26'h0 && !readdata[0]) else $error("bad vector bits");
	a_vector_range: assert property (
		read && waitrequest && address[7:2] == `ARC_IDX_IV |=>
		readdata[5:0] <= 6'h24) else $error("vector code out of range");
	a_slot_unsigned: assert property (
		read && waitrequest && address[7] && !address[2] && !readback_format |=>
		readdata[31:12] == 20'h0 && (resolution_select != 2'h0 || readdata[11:8] == 4'h0) &&
		(resolution_select != 2'h1 || readdata[11:10] == 2'h0))
		else $error("unsigned slot upper bits set");
	a_slot_signed: assert property (
		read && waitrequest && address[7] && !address[2] && readback_format |=>
		readdata[31:16] == 16'h0 && readdata[3:0] == 4'h0 &&
		(resolution_select != 2'h0 || readdata[7:4] == 4'h0) &&
		(resolution_select != 2'h1 || readdata[5:4] == 2'h0)) else $error("signed low bits set");
	a_irq_cause: assert property (
		$rose(irq) |-> $past(load_valid || time_overflow || write)) else $error("irq without cause");

	c_irq: cover property ($rose(irq));
	c_iv_read: cover property (read && waitrequest && address[7:2] == `ARC_IDX_IV);
	c_locked: cover property (conversion_enable && write);
endmodule : arc_top_monitor

bind arc_top arc_top_monitor mon_u (.clock, .rst, .address, .read, .write, .readdata,
	.waitrequest, .irq, .load_valid, .time_overflow, .ctrl_slot, .end_of_sequence_mark,
	.reference_select, .input_channel_select, .conversion_enable, .resolution_select,
	.readback_format, .conversion_cycles);

// ===== dv/arc_top_tb.sv
// Self-checking bench of the result and interrupt block.
// Assumes arc_top and arc_regs.svh; one 50 MHz clock.
`timescale 1ns/1ps
`include "arc_regs.svh"

module arc_top_tb;
	logic        clock = 1'b0, rst = 1'b1, read = 1'b0, write = 1'b0;
	logic        load_valid = 1'b0, time_overflow = 1'b0, waitrequest, irq;
	logic        end_of_sequence_mark, conversion_enable, readback_format;
	logic [7:0]  address = 8'h00;
	logic [31:0] writedata = 32'h0, readdata, rd;
	logic [3:0]  byteenable = 4'hf, load_slot = 4'h0, ctrl_slot = 4'h0;
	logic [3:0]  input_channel_select, conversion_cycles;
	logic [11:0] load_data = 12'h000;
	logic [2:0]  reference_select;
	logic [1:0]  resolution_select;
	logic [15:0] ex;
	int          err_count = 0, compares = 0;

	arc_top dut_u (
		.clock                (clock),
		.rst                  (rst),
		.address              (address),
		.read                 (read),
		.write                (write),
		.writedata            (writedata),
		.byteenable           (byteenable),
		.readdata             (readdata),
		.waitrequest          (waitrequest),
		.irq                  (irq),
		.load_valid           (load_valid),
		.load_slot            (load_slot),
		.load_data            (load_data),
		.time_overflow        (time_overflow),
		.ctrl_slot            (ctrl_slot),
		.end_of_sequence_mark (end_of_sequence_mark),
		.reference_select     (reference_select),
		.input_channel_select (input_channel_select),
		.conversion_enable    (conversion_enable),
		.resolution_select    (resolution_select),
		.readback_format      (readback_format),
		.conversion_cycles    (conversion_cycles)
	);
	always #10 clock = ~clock;

	task end_of_test;
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : end_of_test

	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task bus(input logic we, input logic [5:0] idx, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clock);
		address   <= {idx, 2'h0};
		write     <= we;
		read      <= ~we;
		writedata <= d;
		do begin
			@(posedge clock);
			n++;
		end while (waitrequest !== 1'b0 && n < 20);
		if (n >= 20) begin
			err_count++;
			end_of_test();
		end
		rd = readdata;
		read  <= 1'b0;
		write <= 1'b0;
	endtask : bus

	task rchk(input string nm, input logic [5:0] idx, input logic [31:0] exp);
		bus(1'b0, idx, 32'h0);
		chk(nm, rd, exp);
	endtask : rchk

	task load(input logic [3:0] s, input logic [11:0] d);
		@(posedge clock);
		load_valid <= 1'b1;
		load_slot  <= s;
		load_data  <= d;
		@(posedge clock);
		load_valid <= 1'b0;
		@(posedge clock);
	endtask : load

	initial begin
		repeat (20) @(posedge clock);
		rst <= 1'b0;
		rchk("ie", `ARC_IDX_IE, 32'h0);
		rchk("ifg", `ARC_IDX_IFG, 32'h0);
		rchk("iv", `ARC_IDX_IV, 32'h0);
		chk("res", resolution_select, 2'h2);
		$display("test reset done");
		for (int r = 0; r < 3; r++) begin
			ex = (16'h1 << (8 + 2 * r)) - 16'h1;
			bus(1'b1, `ARC_IDX_CTL2, {26'h0, r[1:0], 4'h0});
			load(r[3:0], 12'hfff);
			chk("cycles", conversion_cycles, 4'h9 + 4'h2 * r[3:0]);
			rchk("raw", `ARC_IDX_MEM_BASE + 6'h2 * r[5:0], {16'h0, ex});
			bus(1'b1, `ARC_IDX_CTL2, {26'h0, r[1:0], 4'h8});
			chk("fmt", readback_format, 1'b1);
			ex = (ex << (8 - 2 * r)) ^ 16'h8000;
			rchk("signed", `ARC_IDX_MEM_BASE + 6'h2 * r[5:0], {16'h0, ex});
		end
		load(4'h2, 12'h000);
		rchk("zero", `ARC_IDX_MEM_BASE + 6'h4, 32'h8000);
		bus(1'b1, `ARC_IDX_CTL2, 32'h30);
		chk("cycles rsv", conversion_cycles, 4'hd);
		bus(1'b1, `ARC_IDX_CTL2, 32'h20);
		$display("test format done");
		bus(1'b1, `ARC_IDX_IE, 32'h0020);
		load(4'h9, 12'h123);
		chk("irq off", irq, 1'b0);
		rchk("ifg", `ARC_IDX_IFG, 32'h0200);
		load(4'h5, 12'h456);
		chk("irq on", irq, 1'b1);
		rchk("iv5", `ARC_IDX_IV, 32'h10);
		rchk("mem5", `ARC_IDX_MEM_BASE + 6'ha, 32'h456);
		chk("irq clr", irq, 1'b0);
		rchk("iv9", `ARC_IDX_IV, 32'h18);
		bus(1'b1, `ARC_IDX_IFG, 32'h0);
		rchk("ifg clr", `ARC_IDX_IFG, 32'h0);
		bus(1'b1, `ARC_IDX_OVF_MASK, 32'h3);
		load(4'h7, 12'h001);
		load(4'h7, 12'h002);
		time_overflow <= 1'b1;
		@(posedge clock);
		time_overflow <= 1'b0;
		@(posedge clock);
		chk("irq ovf", irq, 1'b1);
		rchk("iv res", `ARC_IDX_IV, 32'h2);
		rchk("iv time", `ARC_IDX_IV, 32'h4);
		rchk("iv7", `ARC_IDX_IV, 32'h14);
		chk("irq gate", irq, 1'b0);
		bus(1'b1, `ARC_IDX_IV, 32'hffff);
		rchk("iv ro", `ARC_IDX_IV, 32'h14);
		$display("test interrupt done");
		for (int i = 0; i < 16; i++) begin
			bus(1'b1, `ARC_IDX_MCTL_BASE + i[5:0], {24'h0, i[0], i[2:0], i[3:0]});
			ctrl_slot <= i[3:0];
			repeat (2) @(posedge clock);
			chk("eos", end_of_sequence_mark, i[0]);
			chk("ref", reference_select, i[2:0]);
			chk("inch", input_channel_select, i[3:0]);
		end
		bus(1'b1, `ARC_IDX_CTL0, 32'h2);
		chk("enable", conversion_enable, 1'b1);
		bus(1'b1, `ARC_IDX_MCTL_BASE + 6'hf, 32'h0);
		bus(1'b1, `ARC_IDX_CTL2, 32'h0);
		repeat (2) @(posedge clock);
		chk("lock", input_channel_select, 4'hf);
		chk("res lock", resolution_select, 2'h2);
		rchk("ctl2 lock", `ARC_IDX_CTL2, 32'h20);
		chk("fmt lock", readback_format, 1'b0);
		rchk("unmapped", 6'h3f, 32'h0);
		$display("test control done");
		end_of_test();
	end
endmodule : arc_top_tb
